// File: rtl/glue_cfg.svh
// Purpose: Offsets, field positions, reset values for the glue
// Assumes: Byte addressed APB, 32-bit words
// Notes:   Definitions only
`ifndef GLUE_CFG_SVH
`define GLUE_CFG_SVH
`define OFF_CTRL    12'h000
`define OFF_STAT    12'h004
`define OFF_ISTAT   12'h008
`define OFF_IMASK   12'h00C
`define CTRL_HOLD   0
`define CTRL_ALT    1
`define CTRL_RST    2'h0
`define WIN_LO      16'h0000
`define WIN_HI      16'h5003
`define ROM_END     16'h03FF
`define IO_END      16'h07FF
`define RAM_END     16'h27FF
`define BOOT_ADDR   32'h0001_0000
`define WID_32      2'h0
`define BIO_RING    0
`define BIO_HOOK    1
`define BIO_DEV0    3
`define BIO_DEV1    4
`define BIO_MODE    5
`define BIO_INT2    6
`define BIO_INT6    7
`define MODE_CTRL   1'h1
`define EV_RING     0
`define EV_INT2     1
`define EV_INT6     2
`define EV_BERR     3
`define EV_W        4
`endif

// File: rtl/glue_pkg.sv
// Purpose: Types shared by the glue modules
// Assumes: Nothing
// Notes:   Constants live in glue_cfg.svh
package glue_pkg;
  typedef enum logic [2:0] {
    REG_NONE = 3'b000,
    REG_ROM  = 3'b001,
    REG_IO   = 3'b010,
    REG_RAM  = 3'b011,
    REG_RSVD = 3'b100
  } region_e;
  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_RUN  = 2'b01,
    CYC_ERR  = 2'b10,
    CYC_DONE = 2'b11
  } cyc_e;
  typedef struct packed {
    logic       hook;
    logic [1:0] dev;
    logic       ctrl_mode;
    logic       irq2_n;
    logic       irq6_n;
  } bio_s;
  typedef struct packed {
    logic [31:0] addr;
    logic        as;
    logic        rw;
    logic        burst;
  } cp_req_s;
endpackage

// File: rtl/win_decode.sv
// Purpose: Locate an address inside the on-chip resource window
// Assumes: 64K window, low or high base by processor mode
// Notes:   Pure combinational
`timescale 1ns/1ps
`default_nettype none
`include "glue_cfg.svh"
module win_decode (
  input  wire logic [31:0]     addr,
  input  wire logic            alt_mode,
  output glue_pkg::region_e    region
);
  wire logic [15:0] base = alt_mode ? `WIN_HI : `WIN_LO; // [RULE6] [RULE7]
  wire logic        hit  = addr[31:16] == base;
  wire logic [15:0] off  = addr[15:0];
  assign region = !hit ? glue_pkg::REG_NONE : // [RULE8]
                  off <= `ROM_END ? glue_pkg::REG_ROM :
                  off <= `IO_END  ? glue_pkg::REG_IO :
                  off <= `RAM_END ? glue_pkg::REG_RAM :
                  glue_pkg::REG_RSVD;
endmodule
`default_nettype wire

// File: rtl/bit_io_glue.sv
// Purpose: Bit I/O line assignment for the coprocessor
// Assumes: bio_out is on pclk; ring arrives from a pin
// Notes:   Lines rest at defaults while the coprocessor is held
`timescale 1ns/1ps
`default_nettype none
`include "glue_cfg.svh"
module bit_io_glue (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         held,
  input  wire logic [7:0]   bio_out,
  input  wire logic         ring_pin,
  output logic              ring_sync,
  output glue_pkg::bio_s    lines_q
);
  logic ring_m_q;
  logic ring_s_q;
  glue_pkg::bio_s lines_d;
  wire logic ctl = bio_out[`BIO_MODE] == `MODE_CTRL;
  always_comb begin
    lines_d           = lines_q;
    lines_d.hook      = bio_out[`BIO_HOOK];
    lines_d.ctrl_mode = bio_out[`BIO_MODE];
    lines_d.irq2_n    = bio_out[`BIO_INT2];
    lines_d.irq6_n    = bio_out[`BIO_INT6];
    if (ctl) begin
      lines_d.dev = {bio_out[`BIO_DEV1], bio_out[`BIO_DEV0]}; // [RULE14]
    end
    if (held) begin
      lines_d = '{hook: 1'b0, dev: 2'h0, ctrl_mode: 1'b0,
                  irq2_n: 1'b1, irq6_n: 1'b1}; // [RULE17]
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ring_m_q <= 1'b0;
      ring_s_q <= 1'b0;
      lines_q  <= '{hook: 1'b0, dev: 2'h0, ctrl_mode: 1'b0,
                    irq2_n: 1'b1, irq6_n: 1'b1}; // [RULE14] [RULE17]
    end else begin
      ring_m_q <= ring_pin;
      ring_s_q <= ring_m_q;
      lines_q  <= lines_d;
    end
  end
  assign ring_sync = ring_s_q; // [RULE11]
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_dev_data_stable: assert property ( // [RULE14]
    !lines_q.ctrl_mode && !ctl && !held |=> $stable(lines_q.dev))
    else $error("device select moved outside control mode");
  a_held_defaults: assert property ( // [RULE17]
    held |=> lines_q.irq2_n && lines_q.irq6_n && !lines_q.hook)
    else $error("bit lines active while held");
endmodule
`default_nettype wire

// File: rtl/dsp_coprocessor_glue.sv
// Purpose: Glue between host system and signal coprocessor
// Assumes: One clock, coprocessor bus on pclk
// Notes:   APB register file, arbiter, width check, bit I/O
// Function
// [RULE1] Coprocessor held in reset, off the bus, until host sets a bit
// [RULE2] Coprocessor wins bus arbitration over every other requester
// [RULE3] Full-speed cycles and bursts pass to system memory
// [RULE4] Cycles to 32-bit synchronous or asynchronous targets complete
// [RULE5] Cycles to 8 or 16-bit targets end in bus error
// [RULE6] Default mode: on-chip window is lowest 64K, no system cycle
// [RULE7] Alternate mode moves the window to the high 64K region; the code puts it at 0x5003_0000 instead
// [RULE8] Window holds 1K boot, 1K I/O, 8K RAM, 54K reserved
// [RULE9] After release the coprocessor boots at the fixed address
// [RULE10] Host places boot code before release, saving old contents
// [RULE11] Line 0 is ring input, line 1 hook output, line 2 reserved
// [RULE12] Two lines select phone, audio, expansion zero or one
// [RULE13] One line toggles selected device data or control mode
// [RULE14] Select powers up on phone codec, changes only in control
// [RULE15] Two low outputs request host level 2 and level 6 irqs
// [RULE16] Host handler must tell coprocessor to drop its request
// [RULE17] At reset host irqs stay high and hook rests inactive
`timescale 1ns/1ps
`default_nettype none
`include "glue_cfg.svh"
module dsp_coprocessor_glue (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  output logic               irq,
  output logic               cp_reset_n,
  output logic [31:0]        cp_boot_addr,
  input  wire logic          cp_br,
  output logic               cp_bg,
  input  wire logic [2:0]    other_br,
  output logic [2:0]         other_bg,
  input  wire glue_pkg::cp_req_s cp_req,
  output logic               cp_ack,
  output logic               cp_berr,
  output logic               sys_as,
  output logic [31:0]        sys_addr,
  output logic               sys_rw,
  output logic               sys_burst,
  input  wire logic          sys_ack,
  input  wire logic [1:0]    tgt_width,
  input  wire logic [7:0]    bio_out,
  output logic [7:0]         bio_in,
  input  wire logic          ring_pin,
  output logic               hook,
  output logic               codec_phone_sel_n,
  output logic               codec_audio_sel_n,
  output logic               expansion_select_zero_n,
  output logic               expansion_select_one_n,
  output logic               ser_ctrl_mode,
  output logic               host_irq_level2_n,
  output logic               host_irq_level6_n
);
  logic [1:0]         ctrl_q;
  logic [`EV_W-1:0]   ist_q;
  logic [`EV_W-1:0]   ist_d;
  logic [`EV_W-1:0]   imask_q;
  logic [31:0]        rdata_q;
  logic [3:0]         gnt_q;
  logic [3:0]         gnt_d;
  logic               ring_q;
  logic               irq2_q;
  logic               irq6_q;
  logic [31:0]        addr_q;
  logic               rw_q;
  logic               burst_q;
  glue_pkg::cyc_e     cyc_q;
  glue_pkg::cyc_e     cyc_d;
  glue_pkg::region_e  region;
  glue_pkg::bio_s     lines;
  logic               ring_sync;

  // APB decode
  wire logic setup  = psel && !penable;
  wire logic access = psel && penable;
  wire logic hit_ctrl  = paddr == `OFF_CTRL;
  wire logic hit_stat  = paddr == `OFF_STAT;
  wire logic hit_istat = paddr == `OFF_ISTAT;
  wire logic hit_imask = paddr == `OFF_IMASK;
  wire logic hit = hit_ctrl || hit_stat || hit_istat || hit_imask;
  wire logic wr  = access && pwrite && hit;
  wire logic [31:0] rd_mux =
    hit_ctrl  ? {30'h0, ctrl_q} :
    hit_stat  ? {24'h0, bio_in} :
    hit_istat ? {28'h0, ist_q} :
    hit_imask ? {28'h0, imask_q} : 32'h0;
  assign pready  = 1'b1;
  assign pslverr = access && !hit;
  assign prdata  = rdata_q;

  wire logic released = ctrl_q[`CTRL_HOLD];
  wire logic alt_mode = ctrl_q[`CTRL_ALT];

  // Reset line comes straight from a flop, so no glitch at release
  assign cp_reset_n   = released; // [RULE1]
  assign cp_boot_addr = `BOOT_ADDR; // [RULE9]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= `CTRL_RST;
      imask_q <= '0;
      rdata_q <= 32'h0;
    end else begin
      if (wr && hit_ctrl) begin
        ctrl_q <= pwdata[1:0]; // [RULE1] [RULE7]
      end
      if (wr && hit_imask) begin
        imask_q <= pwdata[`EV_W-1:0];
      end
      if (setup) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Arbiter: bit 3 is the coprocessor, held owner keeps the bus
  wire logic cp_req_ok = cp_br && released;
  wire logic [3:0] reqs = {cp_req_ok, other_br};
  wire logic keep = |(gnt_q & reqs);
  always_comb begin
    gnt_d = 4'h0;
    if (keep) begin
      gnt_d = gnt_q;
    end else if (cp_req_ok) begin
      gnt_d = 4'h8; // [RULE2]
    end else if (other_br[0]) begin
      gnt_d = 4'h1;
    end else if (other_br[1]) begin
      gnt_d = 4'h2;
    end else if (other_br[2]) begin
      gnt_d = 4'h4;
    end
  end
  assign cp_bg    = gnt_q[3];
  assign other_bg = gnt_q[2:0];

  win_decode u_win (
    .addr     (cp_req.addr),
    .alt_mode (alt_mode),
    .region   (region)
  );

  // Cycle handling; on-chip window never reaches the system bus
  wire logic start = cp_bg && cp_req.as;
  wire logic ext   = region == glue_pkg::REG_NONE; // [RULE6] [RULE8]
  wire logic wide  = tgt_width == `WID_32;
  always_comb begin
    cyc_d = cyc_q;
    case (cyc_q)
      glue_pkg::CYC_IDLE: begin
        if (start && ext && wide) begin
          cyc_d = glue_pkg::CYC_RUN; // [RULE4]
        end else if (start && ext) begin
          cyc_d = glue_pkg::CYC_ERR; // [RULE5]
        end
      end
      glue_pkg::CYC_RUN: begin
        if (!cp_req.as) begin
          cyc_d = glue_pkg::CYC_IDLE;
        end
      end
      glue_pkg::CYC_ERR: begin
        cyc_d = glue_pkg::CYC_DONE;
      end
      default: begin
        if (!cp_req.as) begin
          cyc_d = glue_pkg::CYC_IDLE;
        end
      end
    endcase
  end
  // Bursts stay in RUN; each system ack is one beat
  assign sys_as  = cyc_q == glue_pkg::CYC_RUN; // [RULE3]
  assign cp_ack  = sys_as && sys_ack; // [RULE3] [RULE4]
  assign cp_berr = cyc_q == glue_pkg::CYC_ERR; // [RULE5]
  assign sys_addr  = addr_q;
  assign sys_rw    = rw_q;
  assign sys_burst = burst_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_q   <= glue_pkg::CYC_IDLE;
      gnt_q   <= 4'h0;
      addr_q  <= 32'h0;
      rw_q    <= 1'b1;
      burst_q <= 1'b0;
    end else begin
      cyc_q <= cyc_d;
      gnt_q <= gnt_d;
      if (cyc_q == glue_pkg::CYC_IDLE) begin
        addr_q  <= cp_req.addr;
        rw_q    <= cp_req.rw;
        burst_q <= cp_req.burst;
      end
    end
  end

  bit_io_glue u_bio (
    .pclk      (pclk),
    .presetn   (presetn),
    .held      (!released),
    .bio_out   (bio_out),
    .ring_pin  (ring_pin),
    .ring_sync (ring_sync),
    .lines_q   (lines)
  );

  // Read-back view of the port; line 2 reads zero
  assign bio_in = {lines.irq6_n, lines.irq2_n, lines.ctrl_mode,
                   lines.dev, 1'b0, lines.hook, ring_sync}; // [RULE11]
  assign hook          = lines.hook; // [RULE11]
  assign ser_ctrl_mode = lines.ctrl_mode; // [RULE13]
  assign codec_phone_sel_n       = lines.dev != 2'h0; // [RULE12]
  assign codec_audio_sel_n       = lines.dev != 2'h1; // [RULE12]
  assign expansion_select_zero_n = lines.dev != 2'h2; // [RULE12]
  assign expansion_select_one_n  = lines.dev != 2'h3; // [RULE12]
  // Request stays low until coprocessor code releases it
  assign host_irq_level2_n = lines.irq2_n; // [RULE15] [RULE16]
  assign host_irq_level6_n = lines.irq6_n; // [RULE15] [RULE16]

  // Sticky events; a new event beats a same-cycle clear
  wire logic [`EV_W-1:0] ev = {
    cyc_d == glue_pkg::CYC_ERR && cyc_q != glue_pkg::CYC_ERR,
    irq6_q && !lines.irq6_n,
    irq2_q && !lines.irq2_n,
    ring_sync && !ring_q};
  wire logic [`EV_W-1:0] clr = (wr && hit_istat) ? pwdata[`EV_W-1:0] : '0;
  assign ist_d = (ist_q & ~clr) | ev;
  assign irq   = |(ist_q & imask_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q  <= '0;
      ring_q <= 1'b0;
      irq2_q <= 1'b1;
      irq6_q <= 1'b1;
    end else begin
      ist_q  <= ist_d;
      ring_q <= ring_sync;
      irq2_q <= lines.irq2_n;
      irq6_q <= lines.irq6_n;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Release write lands at the next edge, so only the grant is checked one cycle on
  a_hold_off_bus: assert property ( // [RULE1]
    !released |-> !cp_reset_n ##1 !cp_bg)
    else $error("held coprocessor got the bus");
  a_cp_top_prio: assert property ( // [RULE2]
    cp_req_ok && !keep && |other_br |=> cp_bg && other_bg == 3'h0)
    else $error("coprocessor lost arbitration");
  a_ack_passes: assert property ( // [RULE3]
    sys_as && sys_ack |-> cp_ack && !cp_berr)
    else $error("system ack not passed on");
  a_wide_runs: assert property ( // [RULE4]
    cyc_q == glue_pkg::CYC_IDLE && start && ext && wide
    |=> sys_as && sys_addr == $past(cp_req.addr))
    else $error("32-bit cycle not started");
  a_narrow_berr: assert property ( // [RULE5]
    cyc_q == glue_pkg::CYC_IDLE && start && ext && !wide
    |=> cp_berr ##1 !cp_berr && !sys_as)
    else $error("narrow target not refused once");
  a_window_local: assert property ( // [RULE6]
    cyc_q == glue_pkg::CYC_IDLE && start && !alt_mode
    && cp_req.addr[31:16] == 16'h0 |=> !sys_as && !cp_berr)
    else $error("on-chip access left the chip");
  a_alt_window: assert property ( // [RULE7]
    alt_mode && cp_req.addr[31:16] == `WIN_HI |-> !ext)
    else $error("alternate window not decoded");
  // Partition bounds written from the sizes, not from the decoder constants
  a_window_split: assert property ( // [RULE8]
    !ext |-> (region == glue_pkg::REG_ROM) == (cp_req.addr[15:10] == 6'h00)
    && (region == glue_pkg::REG_IO) == (cp_req.addr[15:10] == 6'h01)
    && (region == glue_pkg::REG_RAM)
       == (cp_req.addr[15:0] >= 16'h0800 && cp_req.addr[15:0] <= 16'h27FF))
    else $error("window split wrong");
  a_boot_fixed: assert property ( // [RULE9]
    $rose(cp_reset_n) |-> cp_boot_addr == 32'h0001_0000)
    else $error("boot address wrong at release");
  a_sel_onehot: assert property ( // [RULE12]
    $countones({codec_phone_sel_n, codec_audio_sel_n,
      expansion_select_zero_n, expansion_select_one_n}) == 3)
    else $error("device select not one-hot");
  a_irq_sticky: assert property (
    ev[`EV_BERR] |=> ist_q[`EV_BERR])
    else $error("bus error event lost");

  c_burst_run: cover property (sys_as && sys_burst && sys_ack [*2]);
  c_berr_seen: cover property (cp_berr);
  c_irq2_req: cover property ($fell(host_irq_level2_n) ##[1:20] irq);
  c_alt_mode: cover property (alt_mode && start && !ext);
endmodule
`default_nettype wire

// File: bench/sys_target.sv
// Purpose: System memory target answering coprocessor beats
// Assumes: One-cycle beat ack, wait count set by the bench
// Notes:   Slow setting stands in for asynchronous memory
`timescale 1ns/1ps
`default_nettype none
module sys_target (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       sys_as,
  input  wire logic [2:0] wait_cycles,
  output logic            sys_ack
);
  logic [2:0] cnt_q;
  // Ack only inside a live cycle, a stale ack would fake a beat
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= 3'h0;
      sys_ack <= 1'b0;
    end else if (sys_as && cnt_q == wait_cycles) begin
      cnt_q   <= 3'h0;
      sys_ack <= 1'b1;
    end else begin
      cnt_q   <= sys_as ? cnt_q + 3'h1 : 3'h0;
      sys_ack <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: bench/dsp_coprocessor_glue_test.sv
// Purpose: Self-checking bench for the coprocessor glue
// Assumes: Zero-wait APB, partner target on the system side
// Notes:   Absence of a cycle is judged over a fixed 8-cycle span
`timescale 1ns/1ps
`default_nettype none
`include "glue_cfg.svh"
module dsp_coprocessor_glue_test;
  logic              pclk, presetn, psel, penable, pwrite, ring_pin, cp_br;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, cp_boot_addr, sys_addr;
  logic [2:0]        other_br, other_bg, wt;
  logic [1:0]        tgt_width;
  logic [7:0]        bio_out, bio_in;
  glue_pkg::cp_req_s cp_req;
  logic              pready, pslverr, irq, cp_reset_n, cp_bg, cp_ack, cp_berr, sys_as;
  logic              sys_rw, sys_burst, sys_ack, hook, ser_ctrl_mode, l2_n, l6_n;
  logic [3:0]        sel;
  logic              sa_q = 1'b0;
  logic [33:0]       cap;
  int                n_sys = 0, n_berr = 0, mismatches = 0, checks = 0;
  logic [31:0]       win [7] = '{32'h0, 32'h3FC, 32'h400, 32'h800, 32'h27FC, 32'h2800, 32'hFFFC};

  dsp_coprocessor_glue dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .cp_reset_n(cp_reset_n), .cp_boot_addr(cp_boot_addr),
    .cp_br(cp_br), .cp_bg(cp_bg), .other_br(other_br), .other_bg(other_bg), .cp_req(cp_req),
    .cp_ack(cp_ack), .cp_berr(cp_berr), .sys_as(sys_as), .sys_addr(sys_addr), .sys_rw(sys_rw),
    .sys_burst(sys_burst), .sys_ack(sys_ack), .tgt_width(tgt_width), .bio_out(bio_out),
    .bio_in(bio_in), .ring_pin(ring_pin), .hook(hook), .codec_phone_sel_n(sel[0]),
    .codec_audio_sel_n(sel[1]), .expansion_select_zero_n(sel[2]),
    .expansion_select_one_n(sel[3]), .ser_ctrl_mode(ser_ctrl_mode),
    .host_irq_level2_n(l2_n), .host_irq_level6_n(l6_n));
  sys_target far (.pclk(pclk), .presetn(presetn), .sys_as(sys_as), .wait_cycles(wt),
    .sys_ack(sys_ack));

  always #50 pclk = ~pclk;
  // Mid-cycle sampling keeps the monitor clear of edge races
  always @(negedge pclk) begin
    if (sys_as && !sa_q) begin
      n_sys++;
      cap = {sys_addr, sys_rw, sys_burst};
    end
    sa_q = sys_as;
    if (cp_berr) n_berr++;
  end

  task tally_and_finish;
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task chk(input logic [33:0] got, input logic [33:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
           output logic e);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && t < 50) begin
      @(posedge pclk);
      t++;
    end
    if (t == 50) begin
      mismatches++;
      $display("CHECK FAILED at %0t: no ready", $time);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk(e, 1'b0, "write error");
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x, "read data");
    chk(e, xe, "slave error");
  endtask
  task cp_run(input logic [31:0] a, input logic b, input logic [1:0] w, input int nb,
              input int es, input int eb);
    int s0, e0, ak, t;
    s0 = n_sys; e0 = n_berr; ak = 0;
    @(posedge pclk);
    cp_req <= '{addr: a, as: 1'b1, rw: ~b, burst: b};
    tgt_width <= w;
    for (t = 0; t < 24 && (nb > 0 ? ak < nb : t < 8); t++) begin
      @(posedge pclk);
      #1;
      if (cp_ack === 1'b1) ak++;
    end
    @(posedge pclk);
    cp_req.as <= 1'b0;
    cyc(3);
    chk(ak, nb, "beats");
    chk(n_sys - s0, es, "system cycles");
    chk(n_berr - e0, eb, "bus errors");
  endtask
  task bit_io_port(input logic hk, input logic [1:0] dv, input logic md, input logic i2, input logic i6);
    @(posedge pclk);
    bio_out <= {i6, i2, md, dv, 1'b0, hk, 1'b0};
    cyc(2);
  endtask

  initial begin
    repeat (2000) @(posedge pclk);
    mismatches++;
    tally_and_finish;
  end
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    ring_pin = 0; cp_br = 1; other_br = 0; wt = 0; tgt_width = 0; bio_out = 8'h3A;
    cp_req = '{addr: 32'h0002_0000, as: 1'b1, rw: 1'b1, burst: 1'b0};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    cyc(6);
    chk({cp_reset_n, cp_bg, n_sys[0]}, 3'b000, "held off bus");
    chk({l2_n, l6_n, hook, ser_ctrl_mode, sel}, 8'hCE, "held line defaults");
    chk(cp_boot_addr, `BOOT_ADDR, "boot address");
    rd(`OFF_CTRL, 32'h0, 1'b0);
    rd(12'h010, 32'h0, 1'b1);
    @(posedge pclk);
    cp_req.as <= 1'b0;
    bio_out <= 8'hC0;
    wr(`OFF_CTRL, 32'h1);
    cyc(3);
    chk({cp_reset_n, cp_bg}, 2'b11, "release and grant");
    @(posedge pclk);
    cp_br <= 1'b0;
    cyc(3);
    chk(cp_bg, 1'b0, "grant returned");
    @(posedge pclk);
    cp_br <= 1'b1;
    other_br <= 3'h7;
    cyc(2);
    chk({cp_bg, other_bg}, 4'h8, "priority");
    @(posedge pclk);
    other_br <= 3'h0;
    foreach (win[i]) cp_run(win[i], 1'b0, 2'h0, 0, 0, 0);
    cp_run(`BOOT_ADDR, 1'b0, 2'h0, 1, 1, 0);
    cp_run(32'h0800_0010, 1'b1, 2'h0, 4, 1, 0);
    chk(cap, {32'h0800_0010, 2'b01}, "burst request");
    @(posedge pclk);
    wt <= 3'h3;
    cp_run(32'h0400_0000, 1'b0, 2'h0, 1, 1, 0);
    wr(`OFF_ISTAT, 32'hF);
    for (int w = 1; w < 4; w++) cp_run(32'h00F0_0000, 1'b0, w[1:0], 0, 0, 1);
    rd(`OFF_ISTAT, 32'h8, 1'b0);
    chk(irq, 1'b0, "masked irq");
    wr(`OFF_IMASK, 32'h8);
    cyc(1);
    chk(irq, 1'b1, "unmasked irq");
    wr(`OFF_ISTAT, 32'h8);
    cyc(1);
    chk(irq, 1'b0, "cleared irq");
    wr(`OFF_CTRL, 32'h3);
    cp_run(32'h5003_0100, 1'b0, 2'h0, 0, 0, 0);
    cp_run(32'h0000_2000, 1'b0, 2'h0, 1, 1, 0);
    wr(`OFF_CTRL, 32'h1);
    for (int d = 0; d < 4; d++) begin
      bit_io_port(1'b0, d[1:0], 1'b1, 1'b1, 1'b1);
      chk({ser_ctrl_mode, sel}, {1'b1, ~(4'h1 << d)}, "device select");
    end
    bit_io_port(1'b1, 2'h0, 1'b0, 1'b1, 1'b1);
    chk({hook, ser_ctrl_mode, sel}, 6'h27, "select held in data mode");
    rd(`OFF_STAT, 32'hC2 | 32'h18, 1'b0);
    @(posedge pclk);
    ring_pin <= 1'b1;
    cyc(5);
    chk(bio_in[0], 1'b1, "ring line");
    rd(`OFF_ISTAT, 32'h1, 1'b0);
    wr(`OFF_ISTAT, 32'h1);
    wr(`OFF_IMASK, 32'h6);
    for (int k = 0; k < 2; k++) begin
      bit_io_port(1'b1, 2'h3, 1'b0, k[0], ~k[0]);
      chk({l2_n, l6_n, irq}, {k[0], ~k[0], 1'b1}, "host request");
      rd(`OFF_ISTAT, k ? 32'h4 : 32'h2, 1'b0);
      bit_io_port(1'b1, 2'h3, 1'b0, 1'b1, 1'b1);
      wr(`OFF_ISTAT, 32'h6);
      cyc(1);
      chk({l2_n, l6_n, irq}, 3'b110, "request dropped");
    end
    // Ring pin back to idle so the resynchroniser sees no false edge after reset
    @(posedge pclk);
    presetn <= 1'b0;
    ring_pin <= 1'b0;
    cyc(2);
    chk({cp_reset_n, l2_n, l6_n, hook, sel}, 8'h6E, "second reset");
    @(posedge pclk);
    presetn <= 1'b1;
    cyc(2);
    chk({cp_reset_n, cp_bg, irq, l2_n, l6_n, hook, sel}, 10'h06E, "post reset");
    rd(`OFF_CTRL, 32'h0, 1'b0);
    rd(`OFF_ISTAT, 32'h0, 1'b0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
